/* logic/trig_regs.svh */
`ifndef TRIG_REGS_SVH
`define TRIG_REGS_SVH

// register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_IN_WIDTH 8'h04
`define OFS_OUT_WIDTH 8'h08
`define OFS_VSET 8'h0C
`define OFS_FSET 8'h10
`define OFS_SLOT 8'h14
`define OFS_STATUS 8'h18
`define OFS_CMD 8'h1C

// control register fields
`define CTRL_ACT_LSB 0
`define CTRL_SRC_LSB 4
`define CTRL_ON_BIT 8
`define CTRL_LVL_BIT 9

// command register bits, write-one pulses
`define CMD_OUT_BIT 0
`define CMD_SWITCH_BIT 1
`define CMD_SETTING_BIT 2
`define CMD_PRESET_BIT 3
`define CMD_SURGE_BIT 4

// reset values and limits
`define WIDTH_RST 6'h00
`define WIDTH_MAX 6'h3C
`define IN_DEF_MS 6'h05
`define VSET_RST 16'h0000
`define FSET_MIN 16'h1194
`define FSET_MAX 16'hC350
`define FSET_RST 16'h1194
`define SLOT_MAX 4'h9
`define SLOT_RST 4'h0

// timing
`define MS_NS 1000000
`define CLK_NS 100
`define MS_CYC (`MS_NS / `CLK_NS)

`endif

/* logic/trig_pkg.sv */
package trig_pkg;

    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_OUTPUT = 3'h1,
        ACT_SETTING = 3'h2,
        ACT_PRESET = 3'h3,
        ACT_SURGE = 3'h4
    } in_action_t;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_OUTPUT = 3'h1,
        SRC_SETTING = 3'h2,
        SRC_PRESET = 3'h3,
        SRC_ALL = 3'h4
    } out_src_t;

    typedef enum logic [2:0] {
        Q_IDLE = 3'h1,
        Q_MEAS = 3'h2,
        Q_WAIT = 3'h4
    } qual_state_t;

    // one-cycle event pulses from the instrument
    typedef struct packed {
        logic output_switched;
        logic settings_changed;
        logic preset_loaded;
        logic preset_saved;
    } evt_t;

    // levels: source condition currently true
    typedef struct packed {
        logic output_on;
        logic settings_active;
        logic preset_active;
    } cond_t;

    // requests to the instrument
    typedef struct packed {
        logic out_switch;
        logic out_on;
        logic apply_setting;
        logic [15:0] vset;
        logic [15:0] fset;
        logic preset_load;
        logic [3:0] preset_slot;
        logic surge_dip_action;
    } act_t;

endpackage

/* logic/trigger_pin_controller.sv */
// Contract
// - in simulation or sequence test mode the pin input and pin output behaviour is off.
// - an input pulse counts only if high for the minimum width, 0 meaning 5 ms, else 1-60 ms.
// - with input action none, pin pulses are ignored but remote triggers are taken.
// - with input action output, a trigger sets the power output to the configured on/off.
// - with input action setting, a trigger applies stored voltage and 45.00-500.0 Hz frequency.
// - with input action preset, a trigger loads the preset slot 0 to 9.
// - with input action surge/dip, a trigger starts the surge/dip function.
// - with output source none, no internal event drives the output pin; remote ones still do.
// - with output source output, switching the output on or off activates the pin.
// - with output source setting, a settings change activates the pin.
// - with output source preset, a preset load or save activates the pin.
// - with output source all, any of those events activates the pin.
// - with output width 1-60 ms the pin goes high for exactly that time per activation.
// - with output width 0 the pin holds the chosen level while the source condition holds.
// - the level choice is ignored and not writable while output width is 1-60 ms.
`timescale 1ns/1ps
`include "trig_regs.svh"
module trigger_pin_controller
    import trig_pkg::*;
#(
    parameter int unsigned MS_CYC = `MS_CYC,
    parameter int unsigned AW = 8
)(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // rear_trigger_connector pins
    input wire logic trig_in_pin,
    output logic trig_out_pin,
    // instrument state
    input wire logic sim_mode,
    input wire logic seq_mode,
    input evt_t evt,
    input cond_t cond,
    // requests to the instrument
    output act_t act
);

    if (MS_CYC < 2 || MS_CYC > 65536) begin : g_chk
        $error("MS_CYC out of range");
    end
    if (AW < 8) begin : g_chk_aw
        $error("AW too small");
    end

    localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);

    function automatic logic [5:0] clamp_width(input logic [31:0] v);
        clamp_width = (v > 32'(`WIDTH_MAX)) ? `WIDTH_MAX : v[5:0];
    endfunction

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
        hit = (a == AW'(ofs));
    endfunction

    // configuration
    in_action_t in_action_r;
    out_src_t out_src_r;
    logic out_status_r;
    logic out_level_r;
    logic [5:0] in_width_r;
    logic [5:0] out_width_r;
    logic [15:0] vset_r;
    logic [15:0] fset_r;
    logic [3:0] slot_r;
    logic [4:0] cmd_r;

    // input side
    logic sync1_r;
    logic sync2_r;
    qual_state_t qstate_r;
    logic [15:0] in_pre_r;
    logic [5:0] in_ms_r;
    logic fire_r;

    // output side
    logic busy_r;
    logic [15:0] out_pre_r;
    logic [5:0] out_ms_r;

    logic test_mode;
    logic [5:0] in_need;
    logic src_evt;
    logic src_cond;
    logic [31:0] rdata_nxt;

    assign test_mode = sim_mode | seq_mode;
    assign in_need = (in_width_r == `WIDTH_RST) ? `IN_DEF_MS : in_width_r;

    // register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_action_r <= ACT_NONE;
            out_src_r <= SRC_NONE;
            out_status_r <= 1'b0;
            out_level_r <= 1'b1;
            in_width_r <= `WIDTH_RST;
            out_width_r <= `WIDTH_RST;
            vset_r <= `VSET_RST;
            fset_r <= `FSET_RST;
            slot_r <= `SLOT_RST;
        end else if (wr) begin
            if (hit(addr, `OFS_CTRL)) begin
                // unknown codes keep the old selection
                if (wdata[`CTRL_ACT_LSB+:3] <= ACT_SURGE) begin
                    in_action_r <= in_action_t'(wdata[`CTRL_ACT_LSB+:3]);
                end
                if (wdata[`CTRL_SRC_LSB+:3] <= SRC_ALL) begin
                    out_src_r <= out_src_t'(wdata[`CTRL_SRC_LSB+:3]);
                end
                out_status_r <= wdata[`CTRL_ON_BIT];
                if (out_width_r == `WIDTH_RST) begin
                    out_level_r <= wdata[`CTRL_LVL_BIT];
                end
            end
            if (hit(addr, `OFS_IN_WIDTH)) begin
                in_width_r <= clamp_width(wdata);
            end
            if (hit(addr, `OFS_OUT_WIDTH)) begin
                out_width_r <= clamp_width(wdata);
            end
            if (hit(addr, `OFS_VSET)) begin
                vset_r <= wdata[15:0];
            end
            if (hit(addr, `OFS_FSET)) begin
                if (wdata[15:0] < `FSET_MIN) begin
                    fset_r <= `FSET_MIN;
                end else if (wdata[15:0] > `FSET_MAX) begin
                    fset_r <= `FSET_MAX;
                end else begin
                    fset_r <= wdata[15:0];
                end
            end
            if (hit(addr, `OFS_SLOT) && wdata[3:0] <= `SLOT_MAX && wdata[31:4] == 28'h0) begin
                slot_r <= wdata[3:0];
            end
        end
    end

    // remote trigger commands, one cycle each
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= 5'h00;
        end else if (wr && hit(addr, `OFS_CMD)) begin
            cmd_r <= wdata[4:0];
        end else begin
            cmd_r <= 5'h00;
        end
    end

    // input pin synchroniser
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= trig_in_pin;
            sync2_r <= sync1_r;
        end
    end

    // input pulse qualifier
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            qstate_r <= Q_IDLE;
            in_pre_r <= 16'h0000;
            in_ms_r <= 6'h00;
            fire_r <= 1'b0;
        end else begin
            fire_r <= 1'b0;
            case (qstate_r)
                Q_IDLE: begin
                    in_pre_r <= 16'h0000;
                    in_ms_r <= 6'h00;
                    if (sync2_r) begin
                        qstate_r <= Q_MEAS;
                    end
                end
                Q_MEAS: begin
                    if (!sync2_r) begin
                        qstate_r <= Q_IDLE;
                    end else if (in_pre_r == MS_LAST) begin
                        in_pre_r <= 16'h0000;
                        in_ms_r <= in_ms_r + 6'h01;
                        if (in_ms_r + 6'h01 >= in_need) begin
                            fire_r <= 1'b1;
                            qstate_r <= Q_WAIT;
                        end
                    end else begin
                        in_pre_r <= in_pre_r + 16'h0001;
                    end
                end
                Q_WAIT: begin
                    if (!sync2_r) begin
                        qstate_r <= Q_IDLE;
                    end
                end
                default: begin
                    qstate_r <= Q_IDLE;
                end
            endcase
            // a pulse that overlaps test mode must go low before it counts
            if (test_mode) begin
                qstate_r <= Q_WAIT;
            end
        end
    end

    // requests to the instrument
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act <= '0;
            act.fset <= `FSET_RST;
        end else begin
            act.out_switch <= 1'b0;
            act.apply_setting <= 1'b0;
            act.preset_load <= 1'b0;
            act.surge_dip_action <= 1'b0;
            if (fire_r && !test_mode) begin
                case (in_action_r)
                    ACT_OUTPUT: begin
                        act.out_switch <= 1'b1;
                        act.out_on <= out_status_r;
                    end
                    ACT_SETTING: begin
                        act.apply_setting <= 1'b1;
                        act.vset <= vset_r;
                        act.fset <= fset_r;
                    end
                    ACT_PRESET: begin
                        act.preset_load <= 1'b1;
                        act.preset_slot <= slot_r;
                    end
                    ACT_SURGE: begin
                        act.surge_dip_action <= 1'b1;
                    end
                    default: begin
                        act.out_switch <= 1'b0;
                    end
                endcase
            end
            // remote commands work whatever the input action
            if (!test_mode) begin
                if (cmd_r[`CMD_SWITCH_BIT]) begin
                    act.out_switch <= 1'b1;
                    act.out_on <= out_status_r;
                end
                if (cmd_r[`CMD_SETTING_BIT]) begin
                    act.apply_setting <= 1'b1;
                    act.vset <= vset_r;
                    act.fset <= fset_r;
                end
                if (cmd_r[`CMD_PRESET_BIT]) begin
                    act.preset_load <= 1'b1;
                    act.preset_slot <= slot_r;
                end
                if (cmd_r[`CMD_SURGE_BIT]) begin
                    act.surge_dip_action <= 1'b1;
                end
            end
        end
    end

    // output source selection
    always_comb begin
        case (out_src_r)
            SRC_OUTPUT: begin
                src_evt = evt.output_switched;
                src_cond = cond.output_on;
            end
            SRC_SETTING: begin
                src_evt = evt.settings_changed;
                src_cond = cond.settings_active;
            end
            SRC_PRESET: begin
                src_evt = evt.preset_loaded | evt.preset_saved;
                src_cond = cond.preset_active;
            end
            SRC_ALL: begin
                src_evt = |evt;
                src_cond = |cond;
            end
            default: begin
                src_evt = 1'b0;
                src_cond = 1'b0;
            end
        endcase
    end

    // output pin driver; a new event during a pulse restarts it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_out_pin <= 1'b0;
            busy_r <= 1'b0;
            out_pre_r <= 16'h0000;
            out_ms_r <= 6'h00;
        end else if (test_mode) begin
            trig_out_pin <= 1'b0;
            busy_r <= 1'b0;
        end else if (out_width_r == `WIDTH_RST) begin
            busy_r <= 1'b0;
            if (src_cond || cmd_r[`CMD_OUT_BIT]) begin
                trig_out_pin <= out_level_r;
            end else begin
                trig_out_pin <= ~out_level_r;
            end
        end else if (src_evt || cmd_r[`CMD_OUT_BIT]) begin
            trig_out_pin <= 1'b1;
            busy_r <= 1'b1;
            out_pre_r <= 16'h0000;
            out_ms_r <= 6'h00;
        end else if (busy_r) begin
            if (out_pre_r == MS_LAST) begin
                out_pre_r <= 16'h0000;
                if (out_ms_r + 6'h01 >= out_width_r) begin
                    trig_out_pin <= 1'b0;
                    busy_r <= 1'b0;
                end else begin
                    out_ms_r <= out_ms_r + 6'h01;
                end
            end else begin
                out_pre_r <= out_pre_r + 16'h0001;
            end
        end else begin
            trig_out_pin <= 1'b0;
        end
    end

    // register reads
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(addr, `OFS_CTRL)) begin
            rdata_nxt[`CTRL_ACT_LSB+:3] = in_action_r;
            rdata_nxt[`CTRL_SRC_LSB+:3] = out_src_r;
            rdata_nxt[`CTRL_ON_BIT] = out_status_r;
            rdata_nxt[`CTRL_LVL_BIT] = out_level_r;
        end else if (hit(addr, `OFS_IN_WIDTH)) begin
            rdata_nxt[5:0] = in_width_r;
        end else if (hit(addr, `OFS_OUT_WIDTH)) begin
            rdata_nxt[5:0] = out_width_r;
        end else if (hit(addr, `OFS_VSET)) begin
            rdata_nxt[15:0] = vset_r;
        end else if (hit(addr, `OFS_FSET)) begin
            rdata_nxt[15:0] = fset_r;
        end else if (hit(addr, `OFS_SLOT)) begin
            rdata_nxt[3:0] = slot_r;
        end else if (hit(addr, `OFS_STATUS)) begin
            rdata_nxt[0] = sync2_r;
            rdata_nxt[1] = trig_out_pin;
            rdata_nxt[2] = (qstate_r == Q_IDLE);
            rdata_nxt[3] = test_mode;
            rdata_nxt[4] = busy_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule // trigger_pin_controller

/* test/trigger_pin_controller_asserts.sv */
`timescale 1ns/1ps
`include "trig_regs.svh"
module trig_pin_checker
    import trig_pkg::*;
#(
    parameter int unsigned MS_CYC = 10000,
    parameter int unsigned AW = 8
)(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // pins
    input wire logic trig_in_pin,
    input wire logic trig_out_pin,
    // instrument side
    input wire logic sim_mode,
    input wire logic seq_mode,
    input evt_t evt,
    input cond_t cond,
    input act_t act
);
    logic [5:0] ow_r;
    out_src_t src_r;
    logic lvl_r;
    logic [15:0] hi_r;
    logic tmode;

    assign tmode = sim_mode || seq_mode;

    // shadow of what the pin logic depends on, same refusals as the registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ow_r <= 6'h00;
            src_r <= SRC_NONE;
            lvl_r <= 1'b1;
        end else if (wr && addr == `OFS_OUT_WIDTH) begin
            ow_r <= (wdata > 32'h3C) ? 6'h3C : wdata[5:0];
        end else if (wr && addr == `OFS_CTRL) begin
            if (wdata[6:4] <= 3'h4) begin
                src_r <= out_src_t'(wdata[6:4]);
            end
            if (ow_r == 6'h00) begin
                lvl_r <= wdata[9];
            end
        end
    end

    // length of the current high period on the output pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= 16'h0000;
        end else begin
            hi_r <= trig_out_pin ? hi_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    test_out_a: assert property (tmode |=> !trig_out_pin)
        else $error("output pin active in test mode");
    test_act_a: assert property (tmode [*3] |=> !act.out_switch && !act.apply_setting
        && !act.preset_load && !act.surge_dip_action)
        else $error("action requested in test mode");
    pin_fire_a: assert property (act.surge_dip_action && !$past(wr) && !$past(wr, 2)
        |-> $past(trig_in_pin, 4))
        else $error("action fired without a held input pulse");
    slot_range_a: assert property (act.preset_load |-> act.preset_slot <= `SLOT_MAX)
        else $error("preset slot out of range");
    fset_range_a: assert property (act.apply_setting
        |-> act.fset >= `FSET_MIN && act.fset <= `FSET_MAX)
        else $error("frequency out of range");
    // a pulse cut short by test mode is not an activation that ran its course
    out_width_a: assert property ($fell(trig_out_pin) && ow_r != 6'h00 && !$past(tmode)
        |-> hi_r == ow_r * MS_CYC)
        else $error("output pulse length wrong");
    src_none_a: assert property (ow_r != 6'h00 && src_r == SRC_NONE && !trig_out_pin
        && !wr && !$past(wr) |=> !trig_out_pin)
        else $error("output pin rose with source none");
    src_out_a: assert property (evt.output_switched && src_r == SRC_OUTPUT
        && ow_r != 6'h00 && !tmode |=> trig_out_pin)
        else $error("output switch did not pulse the pin");
    src_all_a: assert property (evt != '0 && src_r == SRC_ALL && ow_r != 6'h00
        && !tmode |=> trig_out_pin)
        else $error("event did not pulse the pin");
    hold_level_a: assert property (ow_r == 6'h00 && src_r == SRC_OUTPUT
        && cond.output_on && !tmode |=> trig_out_pin == $past(lvl_r))
        else $error("held level wrong");

    cover property (act.preset_load);
    cover property ($fell(trig_out_pin) && ow_r != 6'h00);
    cover property (tmode && evt != '0);
endmodule // trig_pin_checker

bind trigger_pin_controller trig_pin_checker #(.MS_CYC(MS_CYC), .AW(AW)) chk_i (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_in_pin(trig_in_pin), .trig_out_pin(trig_out_pin),
    .sim_mode(sim_mode), .seq_mode(seq_mode), .evt(evt), .cond(cond), .act(act)
);

/* test/ext_trigger_rig.sv */
`timescale 1ns/1ps
module ext_trigger_rig (
    // clock
    input wire logic mclk,
    // rear_trigger_connector pins
    input wire logic trig_out_pin,
    output logic trig_in_pin
);
    int hi_len = 0;
    int width = 0;
    int pulses = 0;

    initial trig_in_pin = 1'b0;

    task automatic pulse(input int n);
        @(posedge mclk);
        trig_in_pin <= 1'b1;
        repeat (n) @(posedge mclk);
        trig_in_pin <= 1'b0;
    endtask

    // counts high periods; a held level also counts once it drops
    always @(posedge mclk) begin
        if (trig_out_pin === 1'b1) begin
            hi_len <= hi_len + 1;
        end else begin
            if (hi_len != 0) begin
                width <= hi_len;
                pulses <= pulses + 1;
            end
            hi_len <= 0;
        end
    end
endmodule // ext_trigger_rig

/* test/testbench.sv */
`timescale 1ns/1ps
`include "trig_regs.svh"
module testbench;
    import trig_pkg::*;
    // short millisecond keeps the run small
    localparam int MS = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic trig_in_pin;
    logic trig_out_pin;
    logic sim_mode = 1'b0;
    logic seq_mode = 1'b0;
    evt_t evt = '0;
    cond_t cond = '0;
    act_t act;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int fired [5] = '{0, 0, 0, 0, 0};

    always #50 mclk = ~mclk;

    trigger_pin_controller #(.MS_CYC(MS)) dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trig_in_pin(trig_in_pin), .trig_out_pin(trig_out_pin),
        .sim_mode(sim_mode), .seq_mode(seq_mode), .evt(evt), .cond(cond), .act(act)
    );
    ext_trigger_rig rig (.mclk(mclk), .trig_out_pin(trig_out_pin), .trig_in_pin(trig_in_pin));

    always @(posedge mclk) begin
        fired[1] += act.out_switch;
        fired[2] += act.apply_setting;
        fired[3] += act.preset_load;
        fired[4] += act.surge_dip_action;
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at time %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic pulse_evt(input logic [3:0] e);
        @(posedge mclk);
        evt <= evt_t'(e);
        @(posedge mclk);
        evt <= '0;
    endtask

    initial begin
        int f0 [5];
        int p0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(`OFS_CTRL, 32'h200);
        rd_chk(`OFS_STATUS, 32'h4);
        rd_chk(8'h20, 32'h0);
        rd_chk(`OFS_FSET, 32'h1194);
        wr_reg(`OFS_FSET, 32'h10);
        rd_chk(`OFS_FSET, 32'h1194);
        wr_reg(`OFS_FSET, 32'hFFFF);
        rd_chk(`OFS_FSET, 32'hC350);
        wr_reg(`OFS_SLOT, 32'hA);
        rd_chk(`OFS_SLOT, 32'h0);
        wr_reg(`OFS_SLOT, 32'h9);
        rd_chk(`OFS_SLOT, 32'h9);
        wr_reg(`OFS_VSET, 32'h1234);
        wr_reg(`OFS_IN_WIDTH, 32'h1);
        wr_reg(`OFS_OUT_WIDTH, 32'h2);
        wr_reg(`OFS_CTRL, 32'h0);
        rd_chk(`OFS_CTRL, 32'h200);
        for (int a = 0; a < 5; a++) begin
            wr_reg(`OFS_CTRL, 32'h100 | a);
            f0 = fired;
            rig.pulse(30);
            repeat (8) @(posedge mclk);
            for (int k = 1; k < 5; k++) chk(fired[k] - f0[k], k == a);
        end
        chk(act.out_on, 1);
        chk(act.vset, 32'h1234);
        chk(act.fset, 32'hC350);
        chk(act.preset_slot, 32'h9);
        wr_reg(`OFS_IN_WIDTH, 32'h0);
        wr_reg(`OFS_CTRL, 32'h4);
        f0 = fired;
        rig.pulse(12);
        repeat (8) @(posedge mclk);
        chk(fired[4] - f0[4], 0);
        rig.pulse(40);
        repeat (8) @(posedge mclk);
        chk(fired[4] - f0[4], 1);
        wr_reg(`OFS_CTRL, 32'h0);
        wr_reg(`OFS_CMD, 32'h10);
        repeat (4) @(posedge mclk);
        chk(fired[4] - f0[4], 2);
        // remaining remote commands, output status now off
        f0 = fired;
        wr_reg(`OFS_CMD, 32'hE);
        repeat (4) @(posedge mclk);
        for (int k = 1; k < 4; k++) chk(fired[k] - f0[k], 1);
        chk(act.out_on, 0);
        for (int s = 0; s < 5; s++) begin
            wr_reg(`OFS_CTRL, s << 4);
            for (int b = 0; b < 4; b++) begin
                p0 = rig.pulses;
                pulse_evt(4'h1 << b);
                repeat (12) @(posedge mclk);
                chk(rig.pulses - p0, s == 4 || (s == 1 && b == 3) || (s == 2 && b == 2)
                    || (s == 3 && b < 2));
                if (rig.pulses != p0) chk(rig.width, 2 * MS);
            end
        end
        wr_reg(`OFS_CTRL, 32'h0);
        p0 = rig.pulses;
        wr_reg(`OFS_CMD, 32'h1);
        repeat (12) @(posedge mclk);
        chk(rig.pulses - p0, 1);
        wr_reg(`OFS_OUT_WIDTH, 32'h0);
        wr_reg(`OFS_CTRL, 32'h10);
        rd_chk(`OFS_CTRL, 32'h10);
        @(posedge mclk) cond <= 3'b100;
        repeat (3) @(posedge mclk);
        chk(trig_out_pin, 0);
        @(posedge mclk) cond <= 3'b000;
        repeat (3) @(posedge mclk);
        chk(trig_out_pin, 1);
        // level back to high so the pin is low before pulse mode returns
        wr_reg(`OFS_CTRL, 32'h244);
        wr_reg(`OFS_IN_WIDTH, 32'h1);
        wr_reg(`OFS_OUT_WIDTH, 32'h2);
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk) {seq_mode, sim_mode} <= 2'b01 << m;
            f0 = fired;
            p0 = rig.pulses;
            pulse_evt(4'hF);
            rig.pulse(30);
            repeat (8) @(posedge mclk);
            chk(rig.pulses - p0, 0);
            chk(fired[4] - f0[4], 0);
            rd_chk(`OFS_STATUS, 32'h8);
        end
        @(posedge mclk) {seq_mode, sim_mode} <= 2'b00;
        rig.pulse(30);
        repeat (8) @(posedge mclk);
        chk(fired[4] - f0[4], 1);
        end_of_test();
    end
endmodule // testbench
